// *** src/ppb_pkg.sv ***
package ppb_pkg;

    // ***************************************************
    // configuration space placement
    // ***************************************************
    localparam logic [7:0] CAP_BASE     = 8'h34;
    localparam logic [7:0] PM_CONTROL_STATUS_OFF    = 8'h04;
    localparam logic [7:0] BSE_OFF      = 8'h06;
    localparam logic [7:0] DATA_OFF     = 8'h07;
    localparam logic [7:0] PM_DWORD     = CAP_BASE + PM_CONTROL_STATUS_OFF;
    localparam logic [7:0] DWORD_MASK   = 8'hFC;

    // ***************************************************
    // field positions
    // ***************************************************
    localparam int PS_LSB       = 0;
    localparam int DSEL_LSB     = 9;
    localparam int DSCALE_LSB   = 13;
    localparam int BSE_LSB      = 16;
    localparam int DATA_LSB     = 24;
    localparam int BSE_EN_BIT   = 7;
    localparam int BSE_SEL_BIT  = 6;
    localparam int DSEL_BYTE_LSB = 1;

    localparam logic [1:0] PS_RESET    = 2'h0;
    localparam logic [3:0] DSEL_RESET  = 4'h0;
    localparam logic [1:0] DSCALE_RESET = 2'h0;
    localparam logic [7:0] BSE_RESET   = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
    // supported power states, bit n set when state n accepted
    localparam logic [3:0] PS_SUPPORTED = 4'hF;

    localparam int PS_LANE    = 0;
    localparam int DSEL_LANE  = 1;

    // ***************************************************
    // state encodings
    // ***************************************************
    typedef enum logic [1:0] {
        PPB_D0    = 2'h0,
        PPB_D1    = 2'h1,
        PPB_D2    = 2'h2,
        PPB_D3HOT = 2'h3
    } ppb_pstate_t;

    typedef enum logic [1:0] {
        PPB_B0 = 2'h0,
        PPB_B1 = 2'h1,
        PPB_B2 = 2'h2,
        PPB_B3 = 2'h3
    } ppb_bstate_t;

    typedef enum logic [1:0] {
        PPB_USB_RESET   = 2'h0,
        PPB_USB_OPER    = 2'h1,
        PPB_USB_SUSPEND = 2'h2,
        PPB_USB_RESUME  = 2'h3
    } ppb_usb_t;

    // ***************************************************
    // carriers
    // ***************************************************
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ppb_cfg_req_t;

    typedef struct packed {
        logic        clk_stop;
        logic        pwr_off;
        ppb_bstate_t bstate;
    } ppb_sec_t;

endpackage

// *** src/ppb_sync.sv ***
`timescale 1ns/1ps
module ppb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ***************************************************
    // three stage capture, change taken when 2 and 3 agree
    // ***************************************************
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg  <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg  <= q_next;
        end
    end

    assign q = q_reg;

endmodule

// *** src/ppb_pm_ext.sv ***
`timescale 1ns/1ps
// Operation
// (R01) extension byte at cap+6, read-only, resets zero, bits 5..0 zero
// (R02) bit 7 reports bus power/clock control enabled
// (R03) control disabled: power state writes leave secondary bus untouched
// (R04) bit 6 one stops clock (B2), zero removes power (B3)
// (R05) bit 6 matters only while bit 7 is one
// (R06) D0,D1 to B0,B1 idle; D2 to B2 clock stop; D3cold B3 idle
// (R07) D3hot: clock stops, power removed only for B3
// (R08) data byte at cap+7, read-only, resets zero
// (R09) data byte reports quantity picked by data select
// (R10) data byte scaled by data scale field
// (R11) host supplies running clock and power in B0
// (R12) in B1 nobody starts a bus transaction
// (R13) host keeps power, holds clock low in B2
// (R14) B3 removes clock and supply from the segment
// (R15) usb reset or suspend stops usb system logic
// (R16) usb operational or resume runs usb system logic
// (R17) power state codes D0..D3hot; unsupported writes discarded
// (R18) data select field bits 12..9
// (R19) data scale field bits 14..13, read-only
// (R20) writes to read-only bytes complete, change nothing
module ppb_pm_ext (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  cfg_req,
    input  wire ppb_pkg::ppb_cfg_req_t cfg_cmd,
    output logic                       cfg_ack,
    output logic [31:0]                cfg_rdata,
    input  wire logic                  bus_pwr_clk_ctrl_en_pin,
    input  wire logic                  d3hot_sel_pin,
    input  wire logic                  d3cold_pin,
    input  wire logic [7:0]            data_value,
    input  wire logic [1:0]            data_scale_in,
    input  wire ppb_pkg::ppb_usb_t     usb_bus_state,
    output logic [3:0]                 data_select,
    output logic [1:0]                 power_state,
    output logic                       sec_clk_stop,
    output logic                       sec_pwr_off,
    output logic [1:0]                 sec_bus_state,
    output logic                       usb_logic_run
);

    // ***************************************************
    // declarations
    // ***************************************************
    logic [2:0]           pins_sync;
    logic                 bus_pwr_clk_ctrl_en;
    logic                 d3hot_secondary_state_sel;
    logic                 d3cold;

    ppb_pkg::ppb_pstate_t ps_reg;
    ppb_pkg::ppb_pstate_t ps_next;
    logic [3:0]           dsel_reg;
    logic [3:0]           dsel_next;
    logic [1:0]           dscale_reg;
    logic [1:0]           dscale_next;
    logic [7:0]           bse_reg;
    logic [7:0]           bse_next;
    logic [7:0]           data_reg;
    logic [7:0]           data_next;

    logic                 ack_reg;
    logic                 ack_next;
    logic [31:0]          rdata_reg;
    logic [31:0]          rdata_next;

    ppb_pkg::ppb_sec_t    sec_reg;
    ppb_pkg::ppb_sec_t    sec_next;
    logic                 usb_run_reg;
    logic                 usb_run_next;

    logic                 hit;
    logic                 wr_hit;
    logic [1:0]           new_ps;
    logic [7:0]           ps_byte;
    logic [7:0]           dsel_byte;
    logic [15:0]          pm_control_status;
    logic [31:0]          pm_dword;

    // ***************************************************
    // functions
    // ***************************************************
    function automatic logic [7:0] lane(
        input logic [31:0] w,
        input int          n
    );
        lane = w[n*8 +: 8];
    endfunction

    function automatic logic ps_ok(input logic [1:0] s);
        ps_ok = ps_sup_bit(s);
    endfunction

    function automatic logic ps_sup_bit(input logic [1:0] s);
        ps_sup_bit = ppb_pkg::PS_SUPPORTED[s];
    endfunction

    function automatic ppb_pkg::ppb_sec_t bus_map(
        input ppb_pkg::ppb_pstate_t ps,
        input logic                 en,
        input logic                 sel,
        input logic                 cold
    );
        bus_map.clk_stop = 1'b0;
        bus_map.pwr_off  = 1'b0;
        bus_map.bstate   = ppb_pkg::PPB_B0;
        if (cold) begin
            // (R06) cold: B3, no action
            bus_map.bstate = ppb_pkg::PPB_B3;
            // (R03) state acts only when enabled
        end else if (en) begin
            unique case (ps)
                // (R06) D0 full operation
                ppb_pkg::PPB_D0: begin
                    bus_map.bstate = ppb_pkg::PPB_B0;
                end
                ppb_pkg::PPB_D1: begin
                    // (R12) idle bus, no action
                    bus_map.bstate = ppb_pkg::PPB_B1;
                end
                ppb_pkg::PPB_D2: begin
                    // (R13) clock held stopped
                    bus_map.bstate   = ppb_pkg::PPB_B2;
                    bus_map.clk_stop = 1'b1;
                end
                ppb_pkg::PPB_D3HOT: begin
                    // (R07) clock stops, power for B3
                    bus_map.clk_stop = 1'b1;
                    // (R04) select B2 or B3
                    if (sel) begin
                        bus_map.bstate = ppb_pkg::PPB_B2;
                    end else begin
                        // (R14) supply removed
                        bus_map.bstate  = ppb_pkg::PPB_B3;
                        bus_map.pwr_off = 1'b1;
                    end
                end
            endcase
        end
        // (R03) disabled leaves bus at B0 unless cold, which gives B3
    endfunction

    // ***************************************************
    // pin capture
    // ***************************************************
    // straps and d3cold pin, async to clk
    ppb_sync #(
        .W (3)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({d3cold_pin, d3hot_sel_pin, bus_pwr_clk_ctrl_en_pin}),
        .q     (pins_sync)
    );

    assign bus_pwr_clk_ctrl_en       = pins_sync[0];
    assign d3hot_secondary_state_sel = pins_sync[1];
    assign d3cold                    = pins_sync[2];

    // ***************************************************
    // configuration decode
    // ***************************************************
    assign hit = (cfg_cmd.addr & ppb_pkg::DWORD_MASK)
                 == ppb_pkg::PM_DWORD;
    assign wr_hit = cfg_req & cfg_cmd.wr & hit;
    // byte lanes of the write data
    assign ps_byte   = lane(cfg_cmd.wdata, ppb_pkg::PS_LANE);
    assign dsel_byte = lane(cfg_cmd.wdata, ppb_pkg::DSEL_LANE);
    assign new_ps    = ps_byte[ppb_pkg::PS_LSB +: 2];

    // ***************************************************
    // power management fields
    // ***************************************************
    always_comb begin
        ps_next     = ps_reg;
        dsel_next   = dsel_reg;
        dscale_next = dscale_reg;
        bse_next    = bse_reg;
        data_next   = data_reg;
        // (R17) unsupported state discarded
        if (wr_hit && cfg_cmd.be[ppb_pkg::PS_LANE] && ps_ok(new_ps)) begin
            ps_next = ppb_pkg::ppb_pstate_t'(new_ps);
        end
        // (R18) data select write
        if (wr_hit && cfg_cmd.be[ppb_pkg::DSEL_LANE]) begin
            dsel_next = dsel_byte[ppb_pkg::DSEL_BYTE_LSB +: 4];
        end
        // (R19) scale from function logic
        dscale_next = data_scale_in;
        // (R09) selected quantity
        data_next = data_value;
        // (R01) reserved bits zero
        bse_next = ppb_pkg::BSE_RESET;
        // (R02) enable flag
        bse_next[ppb_pkg::BSE_EN_BIT] = bus_pwr_clk_ctrl_en;
        // (R05) select shown only when enabled
        bse_next[ppb_pkg::BSE_SEL_BIT] = bus_pwr_clk_ctrl_en
                                         & d3hot_secondary_state_sel;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_reg     <= ppb_pkg::PPB_D0;
            dsel_reg   <= ppb_pkg::DSEL_RESET;
            dscale_reg <= ppb_pkg::DSCALE_RESET;
            bse_reg    <= ppb_pkg::BSE_RESET;
            data_reg   <= ppb_pkg::DATA_RESET;
        end else begin
            ps_reg     <= ps_next;
            dsel_reg   <= dsel_next;
            dscale_reg <= dscale_next;
            bse_reg    <= bse_next;
            data_reg   <= data_next;
        end
    end

    // ***************************************************
    // read path
    // ***************************************************
    always_comb begin
        // dword 38h image
        pm_control_status = '0;
        pm_control_status[ppb_pkg::PS_LSB +: 2] = ps_reg;
        pm_control_status[ppb_pkg::DSEL_LSB +: 4] = dsel_reg;
        // (R10) scale beside data select
        pm_control_status[ppb_pkg::DSCALE_LSB +: 2] = dscale_reg;
        pm_dword = ppb_pkg::RD_ZERO;
        pm_dword[15:0] = pm_control_status;
        // (R01) extension byte at cap+6
        pm_dword[ppb_pkg::BSE_LSB +: 8] = bse_reg;
        // (R08) data byte at cap+7
        pm_dword[ppb_pkg::DATA_LSB +: 8] = data_reg;
    end

    always_comb begin
        // every request answered next cycle
        ack_next   = cfg_req;
        rdata_next = ppb_pkg::RD_ZERO;
        // (R20) writes still acknowledged
        if (cfg_req && !cfg_cmd.wr && hit) begin
            rdata_next = pm_dword;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= ppb_pkg::RD_ZERO;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ***************************************************
    // secondary bus and usb control
    // ***************************************************
    always_comb begin
        // (R06) state to bus mapping
        sec_next = bus_map(ps_reg, bus_pwr_clk_ctrl_en,
                           d3hot_secondary_state_sel, d3cold);
        // (R15) stop in reset or suspend
        usb_run_next = 1'b0;
        unique case (usb_bus_state)
            ppb_pkg::PPB_USB_RESET: begin
                usb_run_next = 1'b0;
            end
            ppb_pkg::PPB_USB_SUSPEND: begin
                usb_run_next = 1'b0;
            end
            // (R16) run when active
            ppb_pkg::PPB_USB_OPER: begin
                usb_run_next = 1'b1;
            end
            ppb_pkg::PPB_USB_RESUME: begin
                usb_run_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_reg     <= '0;
            usb_run_reg <= 1'b0;
        end else begin
            sec_reg     <= sec_next;
            usb_run_reg <= usb_run_next;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    // all outputs straight from flops
    assign cfg_ack       = ack_reg;
    assign cfg_rdata     = rdata_reg;
    assign data_select   = dsel_reg;
    assign power_state   = ps_reg;
    assign sec_clk_stop  = sec_reg.clk_stop;
    assign sec_pwr_off   = sec_reg.pwr_off;
    assign sec_bus_state = sec_reg.bstate;
    assign usb_logic_run = usb_run_reg;

endmodule

// *** bench/ppb_pm_ext_monitor.sv ***
`timescale 1ns/1ps
module ppb_pm_ext_monitor (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  cfg_req,
    input wire ppb_pkg::ppb_cfg_req_t cfg_cmd,
    input wire logic                  cfg_ack,
    input wire logic [31:0]           cfg_rdata,
    input wire logic [7:0]            data_value,
    input wire logic [1:0]            data_scale_in,
    input wire ppb_pkg::ppb_usb_t     usb_bus_state,
    input wire logic [3:0]            data_select,
    input wire logic [1:0]            power_state,
    input wire logic                  sec_clk_stop,
    input wire logic                  sec_pwr_off,
    input wire logic [1:0]            sec_bus_state,
    input wire logic                  usb_logic_run
);
    // ********
    // helper state
    // ********
    logic rd_reg, rd_next, wr_reg, wr_next;
    always_comb begin
        rd_next = cfg_req && !cfg_cmd.wr && (cfg_cmd.addr[7:2] == 6'h0E);
        wr_next = cfg_req && cfg_cmd.wr && cfg_cmd.be[0]
                  && (cfg_cmd.addr[7:2] == 6'h0E);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else begin
            rd_reg <= rd_next;
            wr_reg <= wr_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ********
    // assertions
    // ********
    chk_ack_after_req: assert property (cfg_req |=> cfg_ack)
        else $error("no ack one cycle after request");
    chk_ack_has_cause: assert property (cfg_ack |-> $past(cfg_req))
        else $error("ack without request");
    chk_ext_reserved: assert property (rd_reg |->
        cfg_rdata[21:16] == 6'h00)
        else $error("reserved extension bits not zero");
    chk_sel_gated: assert property (rd_reg && !cfg_rdata[23] |->
        !cfg_rdata[22])
        else $error("select bit set while control disabled");
    chk_fields_echo: assert property (rd_reg |->
        cfg_rdata[12:9] == data_select && cfg_rdata[1:0] == power_state)
        else $error("read fields differ from outputs");
    chk_data_path: assert property (rd_reg |->
        cfg_rdata[31:24] == $past(data_value, 2)
        && cfg_rdata[14:13] == $past(data_scale_in, 2))
        else $error("data byte or scale wrong");
    chk_state_by_write: assert property (
        $changed(power_state) |-> wr_reg)
        else $error("power state changed without write");
    chk_pwr_off_b3: assert property (sec_pwr_off |->
        sec_clk_stop && sec_bus_state == 2'h3)
        else $error("power removed outside B3");
    chk_b2_keeps_pwr: assert property (sec_bus_state == 2'h2 |->
        sec_clk_stop && !sec_pwr_off)
        else $error("B2 with wrong actions");
    chk_b0_b1_idle: assert property (
        sec_bus_state inside {2'h0, 2'h1} |-> !sec_clk_stop && !sec_pwr_off)
        else $error("B0 or B1 with action");
    chk_usb_follow: assert property ($past(rst_n) |->
        usb_logic_run == ($past(usb_bus_state) == ppb_pkg::PPB_USB_OPER
        || $past(usb_bus_state) == ppb_pkg::PPB_USB_RESUME))
        else $error("usb run does not follow bus state");
endmodule

bind ppb_pm_ext ppb_pm_ext_monitor u_mon (.clk(clk), .rst_n(rst_n),
    .cfg_req(cfg_req), .cfg_cmd(cfg_cmd), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .data_value(data_value),
    .data_scale_in(data_scale_in), .usb_bus_state(usb_bus_state),
    .data_select(data_select), .power_state(power_state),
    .sec_clk_stop(sec_clk_stop), .sec_pwr_off(sec_pwr_off),
    .sec_bus_state(sec_bus_state), .usb_logic_run(usb_logic_run));

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic                  clk, rst_n, cfg_req, cfg_ack, usb_logic_run;
    logic                  bus_pwr_clk_ctrl_en_pin, d3hot_sel_pin, d3cold_pin;
    logic                  sec_clk_stop, sec_pwr_off;
    ppb_pkg::ppb_cfg_req_t cfg_cmd;
    ppb_pkg::ppb_usb_t     usb_bus_state;
    logic [31:0]           cfg_rdata, rd;
    logic [7:0]            data_value;
    logic [3:0]            data_select;
    logic [1:0]            data_scale_in, power_state, sec_bus_state;
    int                    errors, n_checks;

    ppb_pm_ext DUT (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .cfg_cmd(cfg_cmd), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .bus_pwr_clk_ctrl_en_pin(bus_pwr_clk_ctrl_en_pin), .d3hot_sel_pin(d3hot_sel_pin),
        .d3cold_pin(d3cold_pin), .data_value(data_value),
        .data_scale_in(data_scale_in), .usb_bus_state(usb_bus_state),
        .data_select(data_select), .power_state(power_state),
        .sec_clk_stop(sec_clk_stop), .sec_pwr_off(sec_pwr_off),
        .sec_bus_state(sec_bus_state), .usb_logic_run(usb_logic_run));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ********
    // tasks
    // ********
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask
    task end_sim;
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task cfg(input logic wr, input logic [7:0] addr, input logic [3:0] be,
             input logic [31:0] wdata);
        @(posedge clk);
        #1;
        cfg_req = 1'b1;
        cfg_cmd.wr = wr;
        cfg_cmd.addr = addr;
        cfg_cmd.be = be;
        cfg_cmd.wdata = wdata;
        wt(1);
        cfg_req = 1'b0;
        check(32'(cfg_ack), 32'h1);
        rd = cfg_rdata;
    endtask
    // clk_stop, pwr_off, bus state
    function automatic logic [3:0] exp_sec(input logic en, input logic sel,
                                           input logic cold,
                                           input logic [1:0] p);
        if (cold) begin
            return 4'h3;
        end
        if (!en || p == 2'h0) begin
            return 4'h0;
        end
        if (p == 2'h1) begin
            return 4'h1;
        end
        return (p == 2'h3 && !sel) ? 4'hF : 4'hA;
    endfunction
    // ********
    // tests
    // ********
    initial begin
        #(25 * 6000);
        errors = errors + 1;
        end_sim();
    end
    initial begin
        errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        cfg_req = 1'b0;
        cfg_cmd = '0;
        bus_pwr_clk_ctrl_en_pin = 1'b0;
        d3hot_sel_pin = 1'b0;
        d3cold_pin = 1'b0;
        data_value = 8'h00;
        data_scale_in = 2'h0;
        usb_bus_state = ppb_pkg::PPB_USB_RESET;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cfg(1'b0, 8'h38, 4'hF, 32'h0);
        check(rd, 32'h0);
        data_value = 8'h5A;
        data_scale_in = 2'h2;
        cfg(1'b1, 8'h3A, 4'hC, 32'hFFFF_FFFF);
        cfg(1'b0, 8'h3B, 4'hF, 32'h0);
        check(rd, 32'h5A00_4000);
        for (int i = 0; i < 16; i++) begin
            data_value = 8'hC0 ^ 8'(i);
            data_scale_in = 2'(i) ^ 2'h3;
            cfg(1'b1, 8'h39, 4'h2, 32'(i) << 9);
            wt(2);
            check(32'(data_select), 32'(i));
            cfg(1'b0, 8'h38, 4'hF, 32'h0);
            check(32'(rd[31:9]), 32'({data_value, 9'h0,
                  data_scale_in, 4'(i)}));
        end
        for (int m = 0; m < 16; m++) begin
            bus_pwr_clk_ctrl_en_pin = m[3];
            d3hot_sel_pin = m[2];
            wt(6);
            cfg(1'b1, 8'h38, 4'h1, 32'(m[1:0]));
            wt(3);
            check(
                32'({sec_clk_stop, sec_pwr_off, sec_bus_state}),
                32'(exp_sec(m[3], m[2], 1'b0, m[1:0])));
            check(32'(power_state), 32'(m[1:0]));
            cfg(1'b0, 8'h38, 4'hF, 32'h0);
            check(32'(rd[23:16]),
                  32'({m[3], m[3] & m[2], 6'h0}));
        end
        d3cold_pin = 1'b1;
        wt(6);
        check(32'({sec_clk_stop, sec_pwr_off, sec_bus_state}),
              32'(exp_sec(1'b1, 1'b1, 1'b1, 2'h3)));
        d3cold_pin = 1'b0;
        for (int u = 0; u < 4; u++) begin
            usb_bus_state = ppb_pkg::ppb_usb_t'(u);
            wt(2);
            check(32'(usb_logic_run), 32'(u == 1 || u == 3));
        end
        cfg(1'b1, 8'h38, 4'h1, 32'h2);
        rst_n = 1'b0;
        wt(2);
        rst_n = 1'b1;
        wt(1);
        check(32'({power_state, sec_bus_state}), 32'h0);
        end_sim();
    end
endmodule
